// ---- inc/bdsb_pkg.sv ----
// shared types and constants of the background debug status/breakpoint block
package bdsb_pkg;

    // ****************************************************************
    // serial debug commands and carriers
    // ****************************************************************
    typedef enum logic [2:0] {
        CMD_GET_STATUS,
        CMD_SET_CONTROL,
        CMD_FETCH_BKPT,
        CMD_STORE_BKPT,
        CMD_READ_BYTE,
        CMD_STORE_BYTE,
        CMD_HALT
    } bdsb_cmd_code_t;

    typedef struct packed {
        bdsb_cmd_code_t code;
        logic [15:0] addr;
        logic [15:0] data;
    } bdsb_cmd_t;

    // status/control register, bit 7 down to bit 0
    typedef struct packed {
        logic allow_background;
        logic background_active;
        logic breakpoint_enable;
        logic force_or_tag_select;
        logic comm_clock_select;
        logic wait_stop_status;
        logic wait_stop_failure;
        logic data_valid_failure;
    } bdsb_scr_t;

    typedef enum logic {ST_IDLE, ST_MEM} bdsb_mem_state_t;

    // ****************************************************************
    // reset values, masks and addresses
    // ****************************************************************
    localparam logic [7:0] SCR_NORMAL_RESET = 8'h00;
    localparam logic [7:0] SCR_ACTIVE_RESET = 8'hC8;
    // bits the host may write: allow, bkpt enable, force/tag, clock sel
    localparam logic [7:0] SCR_WRITE_MASK = 8'hB8;
    localparam logic [15:0] BKPT_RESET = 16'h0000;
    // force-reset register address in the target's memory space
    localparam logic [15:0] FORCE_RESET_ADDR = 16'h1801;
    localparam int FORCE_RESET_BIT = 0;
    localparam logic [7:0] FORCE_RESET_READ = 8'h00;

endpackage : bdsb_pkg

// ---- rtl/bdsb_bkpt_match.sv ----
// hardware breakpoint address comparator with force/tag split
`timescale 1ns/10ps
module bdsb_bkpt_match
    import bdsb_pkg::*;
(
    // control bits
    input wire logic breakpoint_enable_in,
    input wire logic force_or_tag_select_in,
    input wire logic [15:0] bkpt_addr_in,
    // cpu address bus
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_addr_valid_in,
    input wire logic cpu_opcode_fetch_in,
    // match results
    output logic force_match_out,
    output logic tag_match_out
);

    logic addr_hit;

    // a disabled breakpoint ignores both select bit and address
    assign addr_hit = breakpoint_enable_in & cpu_addr_valid_in &
                      (cpu_addr_in == bkpt_addr_in);
    // force: any bus cycle matches, opcode or not
    assign force_match_out = addr_hit & force_or_tag_select_in;
    // tag: only an opcode fetch gets marked
    assign tag_match_out = addr_hit & ~force_or_tag_select_in &
                           cpu_opcode_fetch_in;

endmodule : bdsb_bkpt_match

// ---- rtl/bdsb_debug_core.sv ----
// debug status/control, breakpoint and force-reset logic of the controller
`timescale 1ns/10ps
module bdsb_debug_core
    import bdsb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // serial debug command port
    input wire logic cmd_valid_in,
    input wire bdsb_cmd_t cmd_in,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    output logic rsp_fail_out,
    // cpu status and breakpoint interface
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_addr_valid_in,
    input wire logic cpu_opcode_fetch_in,
    input wire logic cpu_insn_boundary_in,
    input wire logic cpu_tag_exec_in,
    input wire logic cpu_halted_in,
    input wire logic cpu_wait_stop_in,
    input wire logic cpu_ws_insn_in,
    input wire logic sys_reset_in,
    output logic halt_req_out,
    output logic opcode_tag_out,
    // target memory access
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    // clock choice and target reset
    output logic comm_clk_sel_out,
    output logic target_reset_out
);

    // ****************************************************************
    // reset synchroniser
    // ****************************************************************
    logic rst_meta;
    logic rst_sync_n;

    // async assert, release after two edges
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ****************************************************************
    // command decode
    // ****************************************************************
    bdsb_scr_t scr;
    bdsb_scr_t next_scr;
    logic [15:0] bkpt_addr;
    logic ws_sticky;
    logic force_pending;
    bdsb_mem_state_t mem_state;
    logic trg_rst;
    logic is_status;
    logic is_control;
    logic is_fetch_bkpt;
    logic is_store_bkpt;
    logic is_mem_cmd;
    logic is_halt;
    logic at_force_reg;
    logic mem_blocked;
    logic mem_go;
    logic force_write;
    logic force_read;
    logic force_match;
    logic tag_match;
    logic halt_set;
    logic ws_now;
    logic [7:0] status_word;

    // registers exist only on this serial port, not on the cpu map
    assign is_status = cmd_valid_in & (cmd_in.code == CMD_GET_STATUS);
    assign is_control = cmd_valid_in &
                        (cmd_in.code == CMD_SET_CONTROL);
    assign is_fetch_bkpt = cmd_valid_in &
                           (cmd_in.code == CMD_FETCH_BKPT);
    assign is_store_bkpt = cmd_valid_in &
                           (cmd_in.code == CMD_STORE_BKPT);
    assign is_mem_cmd = cmd_valid_in & (mem_state == ST_IDLE) &
                        ((cmd_in.code == CMD_READ_BYTE) |
                         (cmd_in.code == CMD_STORE_BYTE));
    assign is_halt = cmd_valid_in & (cmd_in.code == CMD_HALT);
    assign at_force_reg = (cmd_in.addr == FORCE_RESET_ADDR);
    // only the serial store-byte reaches the force-reset bit
    assign force_write = is_mem_cmd & at_force_reg &
                         (cmd_in.code == CMD_STORE_BYTE);
    assign force_read = is_mem_cmd & at_force_reg &
                        (cmd_in.code == CMD_READ_BYTE);
    // a wait/stop in flight makes the memory access fail
    assign mem_blocked = cpu_wait_stop_in | cpu_ws_insn_in;
    assign mem_go = is_mem_cmd & ~at_force_reg & ~mem_blocked;
    // any target reset other than the normal one
    assign trg_rst = sys_reset_in | target_reset_out;

    // ****************************************************************
    // breakpoint and halt requests
    // ****************************************************************
    bdsb_bkpt_match u_bkpt (
        .breakpoint_enable_in(scr.breakpoint_enable),
        .force_or_tag_select_in(scr.force_or_tag_select),
        .bkpt_addr_in(bkpt_addr),
        .cpu_addr_in(cpu_addr_in),
        .cpu_addr_valid_in(cpu_addr_valid_in),
        .cpu_opcode_fetch_in(cpu_opcode_fetch_in),
        .force_match_out(force_match),
        .tag_match_out(tag_match)
    );

    // every halt source is gated by allow-background
    assign halt_set = scr.allow_background & ~cpu_halted_in & (
        is_halt |
        (force_pending & cpu_insn_boundary_in) |
        (cpu_tag_exec_in & scr.breakpoint_enable));

    // wait/stop seen now or carried into the halt
    assign ws_now = cpu_wait_stop_in | ws_sticky;
    assign status_word = {scr[7:3], ws_now, scr.wait_stop_failure,
                          1'b0};

    // ****************************************************************
    // status/control register
    // ****************************************************************
    // hardware sets of failure win over the clearing status read
    always_comb begin
        next_scr = scr;
        next_scr.background_active = cpu_halted_in;
        if (is_control) begin
            next_scr = bdsb_scr_t'((cmd_in.data[7:0] & SCR_WRITE_MASK) |
                                   (scr & ~SCR_WRITE_MASK));
            next_scr.background_active = cpu_halted_in;
            // a control write may set allow-background, never clear it
            next_scr.allow_background = scr.allow_background |
                                        cmd_in.data[7];
        end
        if (is_status) begin
            next_scr.wait_stop_failure = 1'b0;
        end
        if (is_mem_cmd & ~at_force_reg & mem_blocked) begin
            next_scr.wait_stop_failure = 1'b1;
        end
        next_scr.wait_stop_status = ws_now;
        next_scr.data_valid_failure = 1'b0;
        // target reset: keep background settings only if halted
        if (trg_rst) begin
            next_scr = scr.background_active ?
                bdsb_scr_t'(SCR_ACTIVE_RESET) :
                bdsb_scr_t'(SCR_NORMAL_RESET);
        end
    end

    // normal reset clears every bit, allow-background included
    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scr <= bdsb_scr_t'(SCR_NORMAL_RESET);
        end else begin
            scr <= next_scr;
        end
    end

    // ****************************************************************
    // breakpoint register and force pending
    // ****************************************************************
    // force match waits for the instruction boundary
    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bkpt_addr <= BKPT_RESET;
            force_pending <= 1'b0;
        end else begin
            if (is_store_bkpt) begin
                bkpt_addr <= cmd_in.data;
            end
            force_pending <= ~trg_rst & ~cpu_halted_in &
                ((force_pending & ~cpu_insn_boundary_in) |
                 force_match);
        end
    end

    // ****************************************************************
    // halt, tag and wait/stop tracking
    // ****************************************************************
    // halt request holds until the cpu reports halted
    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            halt_req_out <= 1'b0;
            opcode_tag_out <= 1'b0;
            ws_sticky <= 1'b0;
        end else begin
            halt_req_out <= ~trg_rst &
                            ((halt_req_out & ~cpu_halted_in) | halt_set);
            opcode_tag_out <= tag_match;
            // set wins over the clear when leaving background
            ws_sticky <= (is_halt & scr.allow_background &
                          cpu_wait_stop_in) |
                         (ws_sticky & ~trg_rst &
                          (cpu_halted_in | halt_req_out));
        end
    end

    // ****************************************************************
    // command answers, memory access and force reset
    // ****************************************************************
    // register answers come one cycle after the command
    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 16'h0000;
            rsp_fail_out <= 1'b0;
            mem_state <= ST_IDLE;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= 16'h0000;
            mem_wdata_out <= 8'h00;
            target_reset_out <= 1'b0;
            comm_clk_sel_out <= 1'b0;
        end else begin
            rsp_valid_out <= is_status | is_control | is_fetch_bkpt |
                             is_store_bkpt | is_halt |
                             (is_mem_cmd & ~mem_go) |
                             (mem_state == ST_MEM);
            rsp_fail_out <= is_mem_cmd & ~at_force_reg & mem_blocked;
            if (is_status) begin
                rsp_data_out <= {8'h00, status_word};
            end else if (is_fetch_bkpt) begin
                rsp_data_out <= bkpt_addr;
            end else if (force_read) begin
                rsp_data_out <= {8'h00, FORCE_RESET_READ};
            end else if (mem_state == ST_MEM) begin
                rsp_data_out <= {8'h00, mem_rdata_in};
            end else begin
                rsp_data_out <= 16'h0000;
            end
            mem_req_out <= mem_go;
            mem_state <= mem_go ? ST_MEM : ST_IDLE;
            if (mem_go) begin
                mem_we_out <= (cmd_in.code == CMD_STORE_BYTE);
                mem_addr_out <= cmd_in.addr;
                mem_wdata_out <= cmd_in.data[7:0];
            end
            target_reset_out <= force_write &
                                cmd_in.data[FORCE_RESET_BIT];
            comm_clk_sel_out <= scr.comm_clock_select;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_sync_n);

    chk_reset_normal_bits: assert property (
        trg_rst && !scr.background_active |=> scr == SCR_NORMAL_RESET)
        else $error("target reset outside background left bits set");
    chk_reset_active_bits: assert property (
        trg_rst && scr.background_active |=> scr == SCR_ACTIVE_RESET)
        else $error("reset in background gave wrong register value");
    chk_halt_refused: assert property (
        !scr.allow_background |=> !$rose(halt_req_out))
        else $error("halt raised while background not allowed");
    chk_allow_sticky: assert property (
        scr.allow_background && !trg_rst |=> scr.allow_background)
        else $error("allow-background cleared without a reset");
    chk_active_follows: assert property (
        !trg_rst |=> scr.background_active == $past(cpu_halted_in))
        else $error("background-active does not track the cpu");
    chk_bkpt_disabled: assert property (
        !scr.breakpoint_enable |=> !opcode_tag_out)
        else $error("opcode tagged with breakpoint disabled");
    chk_force_halt: assert property (
        force_pending && cpu_insn_boundary_in && scr.allow_background &&
        !cpu_halted_in && !trg_rst |=> halt_req_out)
        else $error("forced breakpoint did not request halt");
    chk_tag_halt: assert property (
        cpu_tag_exec_in && scr.allow_background && !trg_rst &&
        scr.breakpoint_enable && !cpu_halted_in |=> halt_req_out)
        else $error("tagged opcode did not request halt");
    chk_clock_select: assert property (
        ##1 comm_clk_sel_out == $past(scr.comm_clock_select))
        else $error("comm clock select output wrong");
    chk_ws_failure: assert property (
        is_mem_cmd && !at_force_reg && mem_blocked && !trg_rst
        |=> rsp_fail_out && scr.wait_stop_failure)
        else $error("wait/stop conflict not flagged");
    chk_dvf_zero: assert property (
        !scr.data_valid_failure)
        else $error("data-valid failure bit set");
    chk_force_read_zero: assert property (
        force_read |=> rsp_valid_out && rsp_data_out == 16'h0000)
        else $error("force-reset register read not zero");
    chk_force_reset_pulse: assert property (
        force_write && cmd_in.data[FORCE_RESET_BIT]
        |=> target_reset_out ##1 !target_reset_out)
        else $error("force-reset write gave no single reset pulse");

    cov_halt_cmd: cover property (is_halt ##1 halt_req_out);
    cov_force_bkpt: cover property (force_pending ##[1:8] halt_req_out);
    cov_force_reset: cover property (target_reset_out);

endmodule : bdsb_debug_core

// ---- verif/bdsb_host_model.sv ----
// behavioural debug host that issues one serial debug command at a time
`timescale 1ns/10ps
module bdsb_host_model
    import bdsb_pkg::*;
(
    // clock
    input wire logic clk_in,
    // command out, answer back
    output logic cmd_valid_out,
    output bdsb_cmd_t cmd_out,
    input wire logic rsp_valid_in,
    input wire logic [15:0] rsp_data_in,
    input wire logic rsp_fail_in
);
    // idle at time zero
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
    end

    // send one command and wait a bounded time for its answer; the caller
    // never starts the next one early, since memory answers come late
    task automatic send(input bdsb_cmd_code_t code,
            input logic [15:0] addr, input logic [15:0] data,
            output logic [15:0] rdata, output logic fail,
            output logic got);
        got = 1'b0;
        rdata = 16'h0000;
        fail = 1'b0;
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_out <= '{code, addr, data};
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        // released fields turn over so a stale value is never trusted
        cmd_out <= ~cmd_out;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_in);
            if (rsp_valid_in === 1'b1) begin
                rdata = rsp_data_in;
                fail = rsp_fail_in;
                got = 1'b1;
                break;
            end
        end
    endtask : send
endmodule : bdsb_host_model

// ---- verif/tb_background_debug_status_breakpoint.sv ----
// self-checking bench of the debug status, control and breakpoint core
`timescale 1ns/10ps
module tb_background_debug_status_breakpoint
    import bdsb_pkg::*;
;
    typedef struct packed {
        bdsb_cmd_code_t c;
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] e;
        logic k;
    } bdsb_row_t;
    // ************************************************************
    // ordinary command rows: code, address, data, answer, compare
    // ************************************************************
    localparam bdsb_row_t ROWS [10] = '{
        '{CMD_GET_STATUS, 16'h0000, 16'h0000, 16'h0000, 1'b1},
        '{CMD_STORE_BKPT, 16'h0000, 16'hA55A, 16'h0000, 1'b0},
        '{CMD_FETCH_BKPT, 16'h0000, 16'h0000, 16'hA55A, 1'b1},
        '{CMD_SET_CONTROL, 16'h0000, 16'h007F, 16'h0000, 1'b0},
        '{CMD_GET_STATUS, 16'h0000, 16'h0000, 16'h0038, 1'b1},
        '{CMD_READ_BYTE, 16'h0042, 16'h0000, 16'h00E7, 1'b1},
        '{CMD_READ_BYTE, 16'h1801, 16'h0000, 16'h0000, 1'b1},
        '{CMD_STORE_BYTE, 16'h1801, 16'h0000, 16'h0000, 1'b0},
        '{CMD_SET_CONTROL, 16'h0000, 16'h0000, 16'h0000, 1'b0},
        '{CMD_GET_STATUS, 16'h0000, 16'h0000, 16'h0000, 1'b1}};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid, rsp_valid, rsp_fail, cpu_addr_valid, cpu_fetch;
    logic cpu_boundary = 1'b0;
    logic cpu_tag_exec = 1'b0;
    logic cpu_halted = 1'b0;
    logic cpu_ws = 1'b0;
    logic resume = 1'b0;
    logic halt_req, opcode_tag, mem_req, mem_we, clk_sel, trst, f, g, t;
    logic [15:0] rsp_data, cpu_addr, mem_addr, d;
    logic [7:0] mem_wdata, mem_rdata;
    bdsb_cmd_t cmd;
    int n_fail = 0;
    int total_checks = 0;
    int n_trst = 0;
    int n_mem = 0;

    always #2 core_clk = ~core_clk;
    // memory answers a pattern of the address, so a stale byte shows
    assign mem_rdata = mem_addr[7:0] ^ 8'hA5;
    // cpu halts a cycle after being asked and runs again on resume
    always @(posedge core_clk) begin
        if (!rst_n) cpu_halted <= 1'b0;
        else if (halt_req === 1'b1) cpu_halted <= 1'b1;
        else if (resume) cpu_halted <= 1'b0;
    end
    // count target resets and forwarded memory requests
    always @(posedge core_clk) begin
        if (trst === 1'b1) n_trst <= n_trst + 1;
        if (mem_req === 1'b1) n_mem <= n_mem + 1;
    end

    bdsb_host_model host (.clk_in(core_clk), .cmd_valid_out(cmd_valid),
        .cmd_out(cmd), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
        .rsp_fail_in(rsp_fail));
    bdsb_debug_core uut (.core_clk_in(core_clk), .rst_n_in(rst_n),
        .cmd_valid_in(cmd_valid), .cmd_in(cmd), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .rsp_fail_out(rsp_fail),
        .cpu_addr_in(cpu_addr), .cpu_addr_valid_in(cpu_addr_valid),
        .cpu_opcode_fetch_in(cpu_fetch),
        .cpu_insn_boundary_in(cpu_boundary),
        .cpu_tag_exec_in(cpu_tag_exec), .cpu_halted_in(cpu_halted),
        .cpu_wait_stop_in(cpu_ws), .cpu_ws_insn_in(1'b0),
        .sys_reset_in(1'b0), .halt_req_out(halt_req),
        .opcode_tag_out(opcode_tag), .mem_req_out(mem_req),
        .mem_we_out(mem_we), .mem_addr_out(mem_addr),
        .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
        .comm_clk_sel_out(clk_sel), .target_reset_out(trst));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // a missing answer is a hang; stop the run there
    task automatic run(input bdsb_cmd_code_t c, input logic [15:0] a, dt);
        host.send(c, a, dt, d, f, g);
        if (g !== 1'b1) begin
            n_fail++;
            $display("mismatch answer expected 1 seen 0");
            finish_test();
        end
    endtask : run
    // watch a fixed window for a halt request
    task automatic expect_halt(input logic want);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(negedge core_clk);
            if (halt_req === 1'b1) seen = 1'b1;
        end
        check("halt request", {15'h0, seen}, {15'h0, want});
    endtask : expect_halt
    // cpu bus cycle hitting 0x2000, then an instruction boundary
    task automatic bus_hit;
        @(posedge core_clk);
        cpu_addr <= 16'h2000;
        cpu_addr_valid <= 1'b1;
        cpu_fetch <= 1'b1;
        @(posedge core_clk);
        cpu_addr <= 16'hDFFF;
        cpu_addr_valid <= 1'b0;
        cpu_fetch <= 1'b0;
        cpu_boundary <= 1'b1;
        @(negedge core_clk);
        t = opcode_tag;
        @(posedge core_clk);
        cpu_boundary <= 1'b0;
    endtask : bus_hit
    task automatic pulse_resume;
        @(posedge core_clk);
        resume <= 1'b1;
        @(posedge core_clk);
        resume <= 1'b0;
    endtask : pulse_resume
    task automatic do_reset;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : do_reset

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        cpu_addr = 16'h0000;
        cpu_addr_valid = 1'b0;
        cpu_fetch = 1'b0;
        do_reset();
        foreach (ROWS[i]) begin
            run(ROWS[i].c, ROWS[i].a, ROWS[i].d);
            if (ROWS[i].c == CMD_READ_BYTE) d = {8'h00, d[7:0]};
            if (ROWS[i].k) check("row answer", d, ROWS[i].e);
        end
        // forwarded store: strobe, address and byte stand after the access
        run(CMD_STORE_BYTE, 16'h0033, 16'h005C);
        check("store not failed", {15'h0, f}, 16'h0000);
        check("store strobe", {15'h0, mem_we}, 16'h0001);
        check("store address", mem_addr, 16'h0033);
        check("store byte", {8'h00, mem_wdata}, 16'h005C);
        check("zero write no reset", n_trst[15:0], 16'h0000);
        $display("test rows done");
        check("clock select default", {15'h0, clk_sel}, 16'h0000);
        run(CMD_SET_CONTROL, 16'h0000, 16'h0008);
        // the select output follows the register one cycle later
        @(negedge core_clk);
        check("clock select bus", {15'h0, clk_sel}, 16'h0001);
        run(CMD_HALT, 16'h0000, 16'h0000);
        expect_halt(1'b0);
        // host allows background at session start, then checks active
        run(CMD_SET_CONTROL, 16'h0000, 16'h0088);
        run(CMD_HALT, 16'h0000, 16'h0000);
        expect_halt(1'b1);
        run(CMD_GET_STATUS, 16'h0000, 16'h0000);
        check("status halted", d, 16'h00C8);
        $display("test halt done");
        // breakpoint programmed while halted
        run(CMD_STORE_BKPT, 16'h0000, 16'h2000);
        run(CMD_SET_CONTROL, 16'h0000, 16'h0098);
        pulse_resume();
        bus_hit();
        expect_halt(1'b0);
        // allow bit written 0 here: it must stay set from before
        run(CMD_SET_CONTROL, 16'h0000, 16'h0038);
        bus_hit();
        expect_halt(1'b1);
        pulse_resume();
        run(CMD_SET_CONTROL, 16'h0000, 16'h00A8);
        bus_hit();
        check("opcode tag", {15'h0, t}, 16'h0001);
        expect_halt(1'b0);
        @(posedge core_clk);
        cpu_tag_exec <= 1'b1;
        @(posedge core_clk);
        cpu_tag_exec <= 1'b0;
        expect_halt(1'b1);
        $display("test breakpoint done");
        pulse_resume();
        cpu_ws <= 1'b1;
        run(CMD_READ_BYTE, 16'h0010, 16'h0000);
        check("wait memory fail", {15'h0, f}, 16'h0001);
        check("wait not forwarded", n_mem[15:0], 16'h0002);
        run(CMD_GET_STATUS, 16'h0000, 16'h0000);
        check("status in wait", d, 16'h00AE);
        // recovery: halt out of wait, then read the status back
        run(CMD_HALT, 16'h0000, 16'h0000);
        expect_halt(1'b1);
        @(posedge core_clk);
        cpu_ws <= 1'b0;
        run(CMD_GET_STATUS, 16'h0000, 16'h0000);
        check("status halted from wait", d, 16'h00EC);
        $display("test wait stop done");
        run(CMD_STORE_BYTE, 16'h1801, 16'h0001);
        @(negedge core_clk);
        check("force reset pulse", n_trst[15:0], 16'h0001);
        run(CMD_GET_STATUS, 16'h0000, 16'h0000);
        check("status active reset", d, 16'h00C8);
        do_reset();
        run(CMD_GET_STATUS, 16'h0000, 16'h0000);
        check("status normal reset", d, 16'h0000);
        check("clock select reset", {15'h0, clk_sel}, 16'h0000);
        $display("test reset done");
        finish_test();
    end
endmodule : tb_background_debug_status_breakpoint
